//--- rtl/cae_defines.svh
// holds offsets, flag positions, reset values and cycle counts of the executor
// assumes inclusion by bare name from every design file that needs them
//
// Overview of operation
// - add-with-carry writes source plus destination plus carry; flags Z,C,N,V,H; 1 cycle.
// - add_imm_word adds constant to register pair; flags Z,C,N,V,S; 2 cycles.
// - sub_imm_word subtracts constant from register pair; flags Z,C,N,V,S; 2 cycles.
// - sub_borrow_op stores destination minus source minus carry; Z,C,N,V,H; 1 cycle.
// - sub_borrow_imm_op stores destination minus constant minus carry; Z,C,N,V,H; 1 cycle.
// - and_imm_op ANDs destination with constant; flags Z,N,V only; 1 cycle.
// - or_imm_op ORs destination with constant; flags Z,N,V only; 1 cycle.
// - bit_clear_op ANDs with 0xFF minus constant; flags Z,N,V; 1 cycle.
// - bit_set_op ORs destination with constant mask; flags Z,N,V; 1 cycle.
// - zero_minus_test ANDs register with itself, value kept; flags Z,N,V; 1 cycle.
// - mixed_sign_multiply puts signed-by-unsigned product in product_pair; Z,C; 2 cycles.
// - fractional multiply shifts product left one before product_pair; Z,C; 2 cycles.
// - indirect_jump_op loads PC from Z pointer; flags kept; 2 cycles.
// - indirect_subroutine_op calls address in Z pointer; flags kept; 3 cycles.
// - compare_skip_eq skips next instruction when registers equal; 1/2/3 cycles.
// - compare_imm_op computes register minus constant, not stored; Z,N,V,C,H; 1 cycle.
// - skip_reg_bit_low skips next instruction when selected register bit is 0.
// - skip_reg_bit_high skips next instruction when selected register bit is 1.
// - skip_io_bit_low skips next instruction when selected I/O bit is 0.
// - direct jump (3) and direct call (4) exist only on 16K and 32K variants.
`ifndef CAE_DEFINES_SVH
`define CAE_DEFINES_SVH

// ****************************************
// status flag positions
// ****************************************
`define CAE_FLAG_C 0
`define CAE_FLAG_Z 1
`define CAE_FLAG_N 2
`define CAE_FLAG_V 3
`define CAE_FLAG_S 4
`define CAE_FLAG_H 5
`define CAE_SREG_RESET 8'h00

// ****************************************
// fixed operands and cycle counts
// ****************************************
`define CAE_BYTE_ONES 8'hFF
`define CAE_PRODUCT_PAIR_ADDR 5'h00
`define CAE_CYC_ONE 3'h1
`define CAE_CYC_TWO 3'h2
`define CAE_CYC_THREE 3'h3
`define CAE_CYC_FOUR 3'h4
`define CAE_SKIP_ONE_WORD 16'h0002
`define CAE_SKIP_TWO_WORD 16'h0003

`endif

//--- rtl/cae_pkg.sv
// types shared by the executor and its testbench
// assumes a pre-decoded instruction with operand values already read
package cae_pkg;

    typedef enum logic [4:0] {
        OP_NONE,
        OP_ADD_CARRY,
        OP_ADD_IMM_WORD,
        OP_SUB_IMM_WORD,
        OP_SUB_BORROW,
        OP_SUB_BORROW_IMM,
        OP_AND_IMM,
        OP_OR_IMM,
        OP_BIT_CLEAR,
        OP_BIT_SET,
        OP_ZERO_MINUS_TEST,
        OP_MIXED_MUL,
        OP_FRAC_MIXED_MUL,
        OP_INDIRECT_JUMP,
        OP_INDIRECT_SUB,
        OP_DIRECT_JUMP,
        OP_DIRECT_SUB,
        OP_COMPARE_SKIP_EQ,
        OP_COMPARE_IMM,
        OP_SKIP_REG_BIT_LOW,
        OP_SKIP_REG_BIT_HIGH,
        OP_SKIP_IO_BIT_LOW
    } cae_op_e;

    typedef struct packed {
        cae_op_e op;
        logic [4:0] rd_addr;
        logic [7:0] rd_val;
        logic [7:0] rr_val;
        logic [7:0] rdh_val;
        logic [7:0] imm;
        logic [2:0] bit_sel;
        logic [7:0] io_val;
        logic [15:0] z_ptr;
        logic [15:0] pc;
        logic [15:0] target;
        logic next_two_word;
    } cae_instr_s;

    typedef struct packed {
        logic valid;
        logic wide;
        logic [4:0] addr;
        logic [15:0] data;
    } cae_wb_s;

    typedef struct packed {
        logic load;
        logic [15:0] value;
    } cae_pc_s;

endpackage : cae_pkg

//--- rtl/cae_mul.sv
// two-cycle 8x8 multiplier with per-operand sign and fractional shift
// assumes start is a one-cycle strobe; product is read one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "cae_defines.svh"

module cae_mul (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // operands
    input wire logic start,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic a_signed,
    input wire logic b_signed,
    input wire logic frac,
    // result
    output var logic [15:0] product_reg,
    output var logic carry_reg
);

    logic signed [17:0] full;
    logic [15:0] raw;

    // nine-bit extension lets one signed multiplier serve all sign mixes
    assign full = $signed({a_signed & a[7], a}) * $signed({b_signed & b[7], b});
    assign raw = full[15:0];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            product_reg <= 16'h0000;
            carry_reg <= 1'b0;
        end
        else if (start)
        begin
            product_reg <= frac ? {raw[14:0], 1'b0} : raw;
            carry_reg <= raw[15];
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_mul_frac;
        @(posedge clk) disable iff (!rst_n)
        start && frac |=> product_reg == {$past(raw[14:0]), 1'b0};
    endproperty
    a_mul_frac: assert property (p_mul_frac) else $error("fractional product not shifted");

endmodule : cae_mul

`default_nettype wire

//--- rtl/cae_exec.sv
// arithmetic, logic, multiply, jump, call, compare and skip executor
// assumes operands are read outside and results written back outside
`timescale 1ns/1ps
`default_nettype none
`include "cae_defines.svh"

module cae_exec #(
    parameter int FLASH_KB = 32
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // instruction stream
    input wire logic INSTR_VALID,
    input wire cae_pkg::cae_instr_s INSTR,
    output var logic INSTR_READY,
    output var logic DONE,
    output var logic ILLEGAL_OP,
    // results
    output var cae_pkg::cae_wb_s WB,
    output var cae_pkg::cae_pc_s PC_OUT,
    output var cae_pkg::cae_pc_s PUSH,
    output var logic [7:0] SREG
);

    // ****************************************
    // elaboration checks
    // ****************************************
    if (FLASH_KB != 16 && FLASH_KB != 32 && FLASH_KB != 64)
    begin : g_bad_flash
        $error("FLASH_KB must be 16, 32 or 64");
    end

    // absolute jumps only fit the smaller program spaces
    localparam logic DIRECT_OK = (FLASH_KB == 16) || (FLASH_KB == 32);

    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rst_sync_reg;
    logic rst_n_i;

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    assign rst_n_i = rst_sync_reg[1];

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic skip_taken(input cae_pkg::cae_instr_s i);
        case (i.op)
            cae_pkg::OP_COMPARE_SKIP_EQ: skip_taken = (i.rd_val == i.rr_val);
            cae_pkg::OP_SKIP_REG_BIT_LOW: skip_taken = !i.rr_val[i.bit_sel];
            cae_pkg::OP_SKIP_REG_BIT_HIGH: skip_taken = i.rr_val[i.bit_sel];
            cae_pkg::OP_SKIP_IO_BIT_LOW: skip_taken = !i.io_val[i.bit_sel];
            default: skip_taken = 1'b0;
        endcase
    endfunction : skip_taken

    function automatic logic [2:0] cycles_of(input cae_pkg::cae_instr_s i);
        case (i.op)
            cae_pkg::OP_ADD_IMM_WORD,
            cae_pkg::OP_SUB_IMM_WORD,
            cae_pkg::OP_MIXED_MUL,
            cae_pkg::OP_FRAC_MIXED_MUL,
            cae_pkg::OP_INDIRECT_JUMP: cycles_of = `CAE_CYC_TWO;
            cae_pkg::OP_INDIRECT_SUB: cycles_of = `CAE_CYC_THREE;
            cae_pkg::OP_DIRECT_JUMP: cycles_of = DIRECT_OK ? `CAE_CYC_THREE : `CAE_CYC_ONE;
            cae_pkg::OP_DIRECT_SUB: cycles_of = DIRECT_OK ? `CAE_CYC_FOUR : `CAE_CYC_ONE;
            cae_pkg::OP_COMPARE_SKIP_EQ,
            cae_pkg::OP_SKIP_REG_BIT_LOW,
            cae_pkg::OP_SKIP_REG_BIT_HIGH,
            cae_pkg::OP_SKIP_IO_BIT_LOW:
            begin
                if (!skip_taken(i))
                    cycles_of = `CAE_CYC_ONE;
                else if (i.next_two_word)
                    cycles_of = `CAE_CYC_THREE;
                else
                    cycles_of = `CAE_CYC_TWO;
            end
            default: cycles_of = `CAE_CYC_ONE;
        endcase
    endfunction : cycles_of

    // byte add/subtract flags; only H,V,N,Z,C are touched
    function automatic logic [7:0] arith_flags(input logic [7:0] old, input logic [7:0] a,
        input logic [7:0] b, input logic [7:0] r, input logic sub);
        logic [7:0] f;
        f = old;
        if (sub)
        begin
            f[`CAE_FLAG_H] = (!a[3] & b[3]) | (b[3] & r[3]) | (r[3] & !a[3]);
            f[`CAE_FLAG_C] = (!a[7] & b[7]) | (b[7] & r[7]) | (r[7] & !a[7]);
            f[`CAE_FLAG_V] = (a[7] & !b[7] & !r[7]) | (!a[7] & b[7] & r[7]);
        end
        else
        begin
            f[`CAE_FLAG_H] = (a[3] & b[3]) | (b[3] & !r[3]) | (!r[3] & a[3]);
            f[`CAE_FLAG_C] = (a[7] & b[7]) | (b[7] & !r[7]) | (!r[7] & a[7]);
            f[`CAE_FLAG_V] = (a[7] & b[7] & !r[7]) | (!a[7] & !b[7] & r[7]);
        end
        f[`CAE_FLAG_N] = r[7];
        f[`CAE_FLAG_Z] = (r == 8'h00);
        arith_flags = f;
    endfunction : arith_flags

    function automatic logic [7:0] logic_flags(input logic [7:0] old, input logic [7:0] r);
        logic [7:0] f;
        f = old;
        f[`CAE_FLAG_V] = 1'b0;
        f[`CAE_FLAG_N] = r[7];
        f[`CAE_FLAG_Z] = (r == 8'h00);
        logic_flags = f;
    endfunction : logic_flags

    // word flags Z,C,N,V,S from the high byte before and the result
    function automatic logic [7:0] word_flags(input logic [7:0] old, input logic hi7,
        input logic [15:0] r, input logic sub);
        logic [7:0] f;
        f = old;
        f[`CAE_FLAG_V] = sub ? (hi7 & !r[15]) : (!hi7 & r[15]);
        f[`CAE_FLAG_C] = sub ? (r[15] & !hi7) : (!r[15] & hi7);
        f[`CAE_FLAG_N] = r[15];
        f[`CAE_FLAG_Z] = (r == 16'h0000);
        f[`CAE_FLAG_S] = r[15] ^ f[`CAE_FLAG_V];
        word_flags = f;
    endfunction : word_flags

    // ****************************************
    // sequencing
    // ****************************************
    logic accept;
    logic finish;
    logic busy_reg;
    logic [2:0] cnt_reg;
    logic [2:0] cyc_in;
    cae_pkg::cae_instr_s cur_reg;
    cae_pkg::cae_instr_s exe;

    assign accept = INSTR_VALID && INSTR_READY;
    assign cyc_in = cycles_of(INSTR);
    assign exe = accept ? INSTR : cur_reg;
    assign finish = (accept && cyc_in == `CAE_CYC_ONE) || (busy_reg && cnt_reg == `CAE_CYC_ONE);

    always_ff @(posedge REF_CLK or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_reg <= 1'b0;
            cnt_reg <= 3'h0;
            INSTR_READY <= 1'b0;
        end
        else if (accept && cyc_in != `CAE_CYC_ONE)
        begin
            busy_reg <= 1'b1;
            cnt_reg <= cyc_in - `CAE_CYC_ONE;
            INSTR_READY <= 1'b0;
        end
        else if (busy_reg && cnt_reg == `CAE_CYC_ONE)
        begin
            busy_reg <= 1'b0;
            cnt_reg <= 3'h0;
            INSTR_READY <= 1'b1;
        end
        else if (busy_reg)
            cnt_reg <= cnt_reg - `CAE_CYC_ONE;
        else
            INSTR_READY <= 1'b1;
    end

    // operands held so the final cycle can compute from them
    always_ff @(posedge REF_CLK or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cur_reg <= '0;
        else if (accept)
            cur_reg <= INSTR;
    end

    // ****************************************
    // multiplier
    // ****************************************
    logic mul_frac;
    logic [15:0] mul_prod;
    logic mul_carry;

    assign mul_frac = (INSTR.op == cae_pkg::OP_FRAC_MIXED_MUL);

    cae_mul u_mul (
        .clk(REF_CLK),
        .rst_n(rst_n_i),
        .start(accept),
        .a(INSTR.rd_val),
        .b(INSTR.rr_val),
        .a_signed(1'b1),
        .b_signed(1'b0),
        .frac(mul_frac),
        .product_reg(mul_prod),
        .carry_reg(mul_carry)
    );

    // ****************************************
    // execute
    // ****************************************
    logic [7:0] d;
    logic [7:0] k;
    logic [7:0] cin;
    logic [7:0] r8;
    logic [15:0] pair;
    logic [15:0] r16;
    logic [7:0] f_next;
    logic wr;
    logic wide;
    logic pcl;
    logic psh;
    logic ill;
    logic [15:0] pcv;
    logic [15:0] pshv;

    assign d = exe.rd_val;
    assign k = exe.imm;
    assign cin = {7'h00, SREG[`CAE_FLAG_C]};
    assign pair = {exe.rdh_val, exe.rd_val};

    always_comb
    begin
        r8 = 8'h00;
        r16 = 16'h0000;
        f_next = SREG;
        wr = 1'b0;
        wide = 1'b0;
        pcl = 1'b0;
        psh = 1'b0;
        ill = 1'b0;
        pcv = 16'h0000;
        pshv = 16'h0000;
        case (exe.op)
            cae_pkg::OP_ADD_CARRY:
            begin
                r8 = d + exe.rr_val + cin;
                f_next = arith_flags(SREG, d, exe.rr_val, r8, 1'b0);
                wr = 1'b1;
            end
            cae_pkg::OP_SUB_BORROW:
            begin
                r8 = d - exe.rr_val - cin;
                f_next = arith_flags(SREG, d, exe.rr_val, r8, 1'b1);
                wr = 1'b1;
            end
            cae_pkg::OP_SUB_BORROW_IMM:
            begin
                r8 = d - k - cin;
                f_next = arith_flags(SREG, d, k, r8, 1'b1);
                wr = 1'b1;
            end
            cae_pkg::OP_COMPARE_IMM:
            begin
                r8 = d - k;
                f_next = arith_flags(SREG, d, k, r8, 1'b1);
            end
            cae_pkg::OP_ADD_IMM_WORD:
            begin
                r16 = pair + {8'h00, k};
                f_next = word_flags(SREG, exe.rdh_val[7], r16, 1'b0);
                wr = 1'b1;
                wide = 1'b1;
            end
            cae_pkg::OP_SUB_IMM_WORD:
            begin
                r16 = pair - {8'h00, k};
                f_next = word_flags(SREG, exe.rdh_val[7], r16, 1'b1);
                wr = 1'b1;
                wide = 1'b1;
            end
            cae_pkg::OP_AND_IMM,
            cae_pkg::OP_OR_IMM,
            cae_pkg::OP_BIT_SET,
            cae_pkg::OP_BIT_CLEAR,
            cae_pkg::OP_ZERO_MINUS_TEST:
            begin
                if (exe.op == cae_pkg::OP_AND_IMM)
                    r8 = d & k;
                else if (exe.op == cae_pkg::OP_BIT_CLEAR)
                    r8 = d & (`CAE_BYTE_ONES - k);
                else if (exe.op == cae_pkg::OP_ZERO_MINUS_TEST)
                    r8 = d & d;
                else
                    r8 = d | k;
                f_next = logic_flags(SREG, r8);
                wr = 1'b1;
            end
            cae_pkg::OP_MIXED_MUL,
            cae_pkg::OP_FRAC_MIXED_MUL:
            begin
                r16 = mul_prod;
                f_next[`CAE_FLAG_Z] = (mul_prod == 16'h0000);
                f_next[`CAE_FLAG_C] = mul_carry;
                wr = 1'b1;
                wide = 1'b1;
            end
            cae_pkg::OP_INDIRECT_JUMP:
            begin
                pcl = 1'b1;
                pcv = exe.z_ptr;
            end
            cae_pkg::OP_INDIRECT_SUB:
            begin
                pcl = 1'b1;
                pcv = exe.z_ptr;
                psh = 1'b1;
                pshv = exe.pc + 16'h0001;
            end
            cae_pkg::OP_DIRECT_JUMP,
            cae_pkg::OP_DIRECT_SUB:
            begin
                // larger variants refuse the absolute forms
                pcl = DIRECT_OK;
                ill = !DIRECT_OK;
                pcv = exe.target;
                psh = DIRECT_OK && exe.op == cae_pkg::OP_DIRECT_SUB;
                pshv = exe.pc + 16'h0002;
            end
            cae_pkg::OP_COMPARE_SKIP_EQ,
            cae_pkg::OP_SKIP_REG_BIT_LOW,
            cae_pkg::OP_SKIP_REG_BIT_HIGH,
            cae_pkg::OP_SKIP_IO_BIT_LOW:
            begin
                pcl = skip_taken(exe);
                pcv = exe.pc + (exe.next_two_word ? `CAE_SKIP_TWO_WORD : `CAE_SKIP_ONE_WORD);
            end
            default:
            begin
                f_next = SREG;
            end
        endcase
    end

    // ****************************************
    // result registers
    // ****************************************
    always_ff @(posedge REF_CLK or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            WB <= '0;
            DONE <= 1'b0;
            ILLEGAL_OP <= 1'b0;
        end
        else
        begin
            DONE <= finish;
            ILLEGAL_OP <= finish && ill;
            WB.valid <= finish && wr;
            WB.wide <= wide;
            WB.addr <= wide && r16 == mul_prod && exe.op inside {cae_pkg::OP_MIXED_MUL,
                cae_pkg::OP_FRAC_MIXED_MUL} ? `CAE_PRODUCT_PAIR_ADDR : exe.rd_addr;
            WB.data <= wide ? r16 : {8'h00, r8};
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            PC_OUT <= '0;
            PUSH <= '0;
        end
        else
        begin
            PC_OUT.load <= finish && pcl;
            PC_OUT.value <= pcv;
            PUSH.load <= finish && psh;
            PUSH.value <= pshv;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n_i)
    begin
        if (!rst_n_i)
            SREG <= `CAE_SREG_RESET;
        else if (finish)
            SREG <= f_next;
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_take(cae_pkg::cae_op_e o);
        accept && INSTR.op == o;
    endsequence

    property p_adc_one;
        s_take(cae_pkg::OP_ADD_CARRY) |=> DONE && WB.valid && INSTR_READY;
    endproperty
    a_adc_one: assert property (p_adc_one) else $error("add with carry not one cycle");

    property p_word_two;
        s_take(cae_pkg::OP_ADD_IMM_WORD) |=> !INSTR_READY && !DONE ##1 DONE && WB.wide;
    endproperty
    a_word_two: assert property (p_word_two) else $error("word add not two cycles");

    property p_sub_imm_word_two;
        s_take(cae_pkg::OP_SUB_IMM_WORD) |=> !DONE ##1 DONE && WB.valid;
    endproperty
    a_sub_imm_word_two: assert property (p_sub_imm_word_two) else $error("word subtract not two cycles");

    property p_and_v;
        s_take(cae_pkg::OP_AND_IMM) |=> !SREG[`CAE_FLAG_V]
            && SREG[`CAE_FLAG_C] == $past(SREG[`CAE_FLAG_C]);
    endproperty
    a_and_v: assert property (p_and_v) else $error("logic op flags wrong");

    property p_indirect_jump_op;
        s_take(cae_pkg::OP_INDIRECT_JUMP) |=> !PC_OUT.load ##1
            PC_OUT.load && PC_OUT.value == $past(cur_reg.z_ptr);
    endproperty
    a_indirect_jump_op: assert property (p_indirect_jump_op) else $error("indirect jump wrong");

    property p_indirect_subroutine_op;
        s_take(cae_pkg::OP_INDIRECT_SUB) |=> $stable(SREG) [*3] ##0 PC_OUT.load && PUSH.load;
    endproperty
    a_indirect_subroutine_op: assert property (p_indirect_subroutine_op) else $error("indirect call wrong");

    property p_cpi;
        s_take(cae_pkg::OP_COMPARE_IMM) |=> DONE && !WB.valid;
    endproperty
    a_cpi: assert property (p_cpi) else $error("compare stored a result");

    property p_skip;
        accept && skip_taken(INSTR) && !INSTR.next_two_word |=> !INSTR_READY ##1
            PC_OUT.load && PC_OUT.value == $past(cur_reg.pc) + 16'h0002;
    endproperty
    a_skip: assert property (p_skip) else $error("skip not taken");

    property p_direct;
        s_take(cae_pkg::OP_DIRECT_JUMP) |=> ILLEGAL_OP == !DIRECT_OK;
    endproperty
    a_direct: assert property (p_direct) else $error("direct jump availability wrong");

endmodule : cae_exec

`default_nettype wire

//--- verif/testbench.sv
// bench for the executor: random and corner instructions, results, flags, timing
// assumes cae_pkg and cae_exec compiled first; single clock, no partner model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic REF_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic INSTR_VALID = 1'b0;
    cae_pkg::cae_instr_s INSTR = '0;
    logic INSTR_READY;
    logic DONE;
    logic ILLEGAL_OP;
    cae_pkg::cae_wb_s WB;
    cae_pkg::cae_pc_s PC_OUT;
    cae_pkg::cae_pc_s PUSH;
    logic [7:0] SREG;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    int e_cyc;
    logic e_wbv;
    logic e_wide;
    logic e_pcl;
    logic e_pul;
    logic [4:0] e_addr;
    logic [15:0] e_data;
    logic [15:0] e_pc;
    logic [15:0] e_push;
    logic [7:0] e_sreg = 8'h00;

    cae_exec #(.FLASH_KB(32)) cae_exec_inst (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
        .INSTR_READY(INSTR_READY), .DONE(DONE), .ILLEGAL_OP(ILLEGAL_OP), .WB(WB),
        .PC_OUT(PC_OUT), .PUSH(PUSH), .SREG(SREG));

    always #12.5 REF_CLK = ~REF_CLK;

    // hang guard, well above the thousand or so cycles the run needs
    always @(posedge REF_CLK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            conclude();
        end
    end

    // ****************************************
    // expectation model
    // ****************************************
    function automatic logic [7:0] znv(logic [7:0] x);
        e_sreg[1] = x == 8'h00;
        e_sreg[2] = x[7];
        e_sreg[3] = 1'b0;
        return x;
    endfunction : znv

    // carry and half carry read as borrow when subtracting
    function automatic logic [7:0] alu(logic [7:0] a, logic [7:0] b, logic ci, logic sub);
        logic [8:0] r;
        logic [4:0] h;
        r = sub ? {1'b0, a} - b - ci : {1'b0, a} + b + ci;
        h = sub ? {1'b0, a[3:0]} - b[3:0] - ci : {1'b0, a[3:0]} + b[3:0] + ci;
        void'(znv(r[7:0]));
        e_sreg[0] = r[8];
        e_sreg[3] = (a[7] ^ b[7] ^ !sub) & (a[7] ^ r[7]);
        e_sreg[5] = h[4];
        return r[7:0];
    endfunction : alu

    function automatic void wr8(logic [7:0] d);
        e_wbv = 1'b1;
        e_data = {8'h00, d};
    endfunction : wr8

    function automatic void wr16(logic [15:0] d);
        e_wbv = 1'b1;
        e_wide = 1'b1;
        e_data = d;
        e_cyc = 2;
        e_sreg[1] = d == 16'h0000;
    endfunction : wr16

    function automatic void direct_jump_op(logic [15:0] to, int c, logic pu, logic [15:0] ret);
        e_pcl = 1'b1;
        e_pc = to;
        e_cyc = c;
        e_pul = pu;
        e_push = ret;
    endfunction : direct_jump_op

    function automatic void predict(cae_pkg::cae_instr_s i);
        logic [16:0] w;
        logic [15:0] p;
        logic sub;
        logic sk;
        e_cyc = 1;
        e_wbv = 1'b0;
        e_wide = 1'b0;
        e_addr = i.rd_addr;
        e_pcl = 1'b0;
        e_pul = 1'b0;
        sk = 1'b0;
        case (i.op)
            cae_pkg::OP_ADD_CARRY: wr8(alu(i.rd_val, i.rr_val, e_sreg[0], 0));
            cae_pkg::OP_SUB_BORROW: wr8(alu(i.rd_val, i.rr_val, e_sreg[0], 1));
            cae_pkg::OP_SUB_BORROW_IMM: wr8(alu(i.rd_val, i.imm, e_sreg[0], 1));
            cae_pkg::OP_COMPARE_IMM: void'(alu(i.rd_val, i.imm, 0, 1));
            cae_pkg::OP_AND_IMM: wr8(znv(i.rd_val & i.imm));
            cae_pkg::OP_OR_IMM, cae_pkg::OP_BIT_SET: wr8(znv(i.rd_val | i.imm));
            cae_pkg::OP_BIT_CLEAR: wr8(znv(i.rd_val & (8'hFF - i.imm)));
            cae_pkg::OP_ZERO_MINUS_TEST: wr8(znv(i.rd_val & i.rd_val));
            cae_pkg::OP_ADD_IMM_WORD, cae_pkg::OP_SUB_IMM_WORD:
            begin
                sub = i.op == cae_pkg::OP_SUB_IMM_WORD;
                w = sub ? {1'b0, i.rdh_val, i.rd_val} - i.imm : {1'b0, i.rdh_val, i.rd_val} + i.imm;
                wr16(w[15:0]);
                e_sreg[0] = w[16];
                e_sreg[2] = w[15];
                e_sreg[3] = (i.rdh_val[7] ^ w[15]) & (w[15] ^ sub);
                e_sreg[4] = w[15] ^ e_sreg[3];
            end
            cae_pkg::OP_MIXED_MUL, cae_pkg::OP_FRAC_MIXED_MUL:
            begin
                p = $signed(i.rd_val) * $signed({1'b0, i.rr_val});
                e_sreg[0] = p[15];
                e_addr = 5'h00;
                wr16(i.op == cae_pkg::OP_MIXED_MUL ? p : p << 1);
            end
            cae_pkg::OP_INDIRECT_JUMP: direct_jump_op(i.z_ptr, 2, 0, 16'h0000);
            cae_pkg::OP_INDIRECT_SUB: direct_jump_op(i.z_ptr, 3, 1, i.pc + 16'h0001);
            cae_pkg::OP_DIRECT_JUMP: direct_jump_op(i.target, 3, 0, 16'h0000);
            cae_pkg::OP_DIRECT_SUB: direct_jump_op(i.target, 4, 1, i.pc + 16'h0002);
            cae_pkg::OP_COMPARE_SKIP_EQ: sk = i.rd_val == i.rr_val;
            cae_pkg::OP_SKIP_REG_BIT_LOW: sk = !i.rr_val[i.bit_sel];
            cae_pkg::OP_SKIP_REG_BIT_HIGH: sk = i.rr_val[i.bit_sel];
            cae_pkg::OP_SKIP_IO_BIT_LOW: sk = !i.io_val[i.bit_sel];
            default: ;
        endcase
        if (sk)
            direct_jump_op(i.pc + (i.next_two_word ? 16'h0003 : 16'h0002), i.next_two_word ? 3 : 2, 0, 16'h0000);
    endfunction : predict

    // ****************************************
    // driver and checks
    // ****************************************
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk

    // about half the equality skips get equal operands
    function automatic cae_pkg::cae_instr_s rnd(cae_pkg::cae_op_e op);
        logic [127:0] x;
        cae_pkg::cae_instr_s i;
        x = {$urandom, $urandom, $urandom, $urandom};
        i = x[$bits(i)-1:0];
        i.op = op;
        if (op inside {cae_pkg::OP_ADD_IMM_WORD, cae_pkg::OP_SUB_IMM_WORD})
            i.imm[7:6] = 2'b00;
        if (x[127] && op == cae_pkg::OP_COMPARE_SKIP_EQ)
            i.rr_val = i.rd_val;
        return i;
    endfunction : rnd

    task automatic exec(cae_pkg::cae_instr_s i);
        int n;
        predict(i);
        @(posedge REF_CLK);
        INSTR <= i;
        INSTR_VALID <= 1'b1;
        n = 0;
        do
            @(posedge REF_CLK);
        while (INSTR_READY !== 1'b1 && ++n < 9);
        INSTR_VALID <= 1'b0;
        // done stands in the cycle right after its launching edge
        n = 1;
        #1;
        while (DONE !== 1'b1 && n < 9)
        begin
            @(posedge REF_CLK);
            #1;
            n++;
        end
        chk(n == e_cyc, "cycle count");
        chk(WB.valid === e_wbv && WB.wide === e_wide, "write strobe");
        chk(!e_wbv || (WB.addr === e_addr && (e_wide ? WB.data === e_data
            : WB.data[7:0] === e_data[7:0])), "write data");
        chk(SREG === e_sreg, "flags");
        chk(PC_OUT.load === e_pcl && (!e_pcl || PC_OUT.value === e_pc), "pc");
        chk(PUSH.load === e_pul && (!e_pul || PUSH.value === e_push), "push");
        chk(ILLEGAL_OP === 1'b0, "illegal");
    endtask : exec

    task automatic conclude();
        if (miscompares == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // ****************************************
    // sequence
    // ****************************************
    initial
    begin
        cae_pkg::cae_instr_s t;
        void'($urandom(32'h99AD620D));
        repeat (8) @(posedge REF_CLK);
        RST_N <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        t = rnd(cae_pkg::OP_SUB_IMM_WORD);
        t.rdh_val = 8'h00;
        t.rd_val = 8'h00;
        t.imm = 8'h01;
        exec(t);
        t = rnd(cae_pkg::OP_ADD_CARRY);
        t.rd_val = 8'hFF;
        t.rr_val = 8'h00;
        exec(t);
        t = rnd(cae_pkg::OP_ADD_IMM_WORD);
        t.rdh_val = 8'hFF;
        t.rd_val = 8'hFF;
        t.imm = 8'h01;
        exec(t);
        t = rnd(cae_pkg::OP_FRAC_MIXED_MUL);
        t.rd_val = 8'h80;
        t.rr_val = 8'hFF;
        exec(t);
        t = rnd(cae_pkg::OP_SKIP_IO_BIT_LOW);
        t.io_val = 8'h00;
        t.next_two_word = 1'b1;
        exec(t);
        for (int k = 1; k <= 21; k++)
            repeat (20) exec(rnd(cae_pkg::cae_op_e'(k)));
        conclude();
    end
endmodule : testbench
`default_nettype wire
